// ### rtl/pwr_mode_pkg.sv
// Package of constants and types for the USB power mode switch.
// Behaviour
// - Supply rising over upper threshold in stand-alone mode raises plug interrupt when enabled.
// - Software reset holds device in reset with every I/O tri-stated as input.
// - Reset into USB mode drives usb_switch_enable_n low during and after reset.
// - Supply falling below lower threshold in USB mode raises plug-change interrupt.
// - Reset into stand-alone mode floats usb_switch_enable_n during and after reset.
// - Stand-alone mode stops the PLL and clocks from the divided crystal.
// - Storage-rail I/Os are held at ground while the storage supply is absent.
// - Software selects regulator output among 2.8, 3.3, 3.4 or 3.5 volts.
// - Voltage select encodes 00=3.5V, 01=3.4V, 10=3.3V, 11=2.8V.
// - plug_detect follows cable; each edge requests an interrupt when enabled.
// - regulator_on powers the storage regulator; clearing it shuts it down.
`default_nettype none
package pwr_mode_pkg;
    localparam logic [3:0] OFF_CTRL   = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ    = 4'h8;
    localparam logic [3:0] OFF_MASK   = 4'hc;
    localparam int BIT_REGULATOR_ON  = 0;
    localparam int BIT_DETOFF = 1;
    localparam int BIT_VSEL   = 2;
    localparam int BIT_PLUG_IRQ_ENABLE  = 4;
    localparam int BIT_RESET  = 8;
    localparam int BIT_PLUG   = 0;
    localparam int BIT_UPPER  = 1;
    localparam int BIT_LOWER  = 2;
    localparam int BIT_USBM   = 3;
    localparam int BIT_INRST  = 4;
    localparam logic [1:0] VSEL_3V5 = 2'h0;
    localparam logic [1:0] VSEL_3V4 = 2'h1;
    localparam logic [1:0] VSEL_3V3 = 2'h2;
    localparam logic [1:0] VSEL_2V8 = 2'h3;
    localparam int CLK_MHZ       = 10;
    localparam int RST_HOLD_NS   = 51200;
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_RESET = 2'b01
    } seq_state_t;
    typedef struct packed {
        logic       plug_irq_enable;
        logic [1:0] regulator_voltage_select;
        logic       detector_off;
        logic       regulator_on;
    } ctrl_t;
    typedef struct packed {
        logic usb_mode;
        logic pll_enable;
        logic clk_sel_pll;
    } mode_t;
endpackage : pwr_mode_pkg
`default_nettype wire

// ### rtl/usb_power_mode_switch.sv
// Power mode sequencer with AXI4-Lite control registers.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
module usb_power_mode_switch
    import pwr_mode_pkg::*;
#(
    parameter int RST_CYC = RST_HOLD_CYC
) (
    input  wire logic        aclk,              // System clock, 10 MHz.
    input  wire logic        aresetn,           // Synchronous reset, active low.
    input  wire logic [3:0]  s_axi_awaddr,      // Write address.
    input  wire logic        s_axi_awvalid,     // Write address valid.
    output logic             s_axi_awready,     // Write address ready.
    input  wire logic [31:0] s_axi_wdata,       // Write data.
    input  wire logic [3:0]  s_axi_wstrb,       // Write strobes.
    input  wire logic        s_axi_wvalid,      // Write data valid.
    output logic             s_axi_wready,      // Write data ready.
    output logic [1:0]       s_axi_bresp,       // Write response.
    output logic             s_axi_bvalid,      // Write response valid.
    input  wire logic        s_axi_bready,      // Write response ready.
    input  wire logic [3:0]  s_axi_araddr,      // Read address.
    input  wire logic        s_axi_arvalid,     // Read address valid.
    output logic             s_axi_arready,     // Read address ready.
    output logic [31:0]      s_axi_rdata,       // Read data.
    output logic [1:0]       s_axi_rresp,       // Read response.
    output logic             s_axi_rvalid,      // Read data valid.
    input  wire logic        s_axi_rready,      // Read data ready.
    input  wire logic        upper_detect,      // Supply above upper detect threshold.
    input  wire logic        lower_detect,      // Supply above lower detect threshold.
    input  wire logic        storage_io_supply, // Storage rail present.
    output logic             usb_switch_enable_n_o,  // Switch enable pin output value.
    output logic             usb_switch_enable_n_oe, // Switch enable pin output enable.
    output logic             io_hiz,            // All I/O ports tri-stated as inputs.
    output logic             storage_io_ground, // Storage-rail I/Os held at ground.
    output logic             pll_enable,        // PLL running.
    output logic             clk_sel_pll,       // Core clock from PLL, else crystal divided.
    output logic             regulator_on,      // Storage regulator power.
    output logic [1:0]       regulator_voltage_select, // Regulator level code.
    output logic             detector_off,      // Supply detector powered down.
    output logic             core_reset,        // Reset held on the core.
    output logic             irq                // Level interrupt.
);

    ctrl_t      ctrl_q;
    mode_t      mode_q;
    seq_state_t state_q;
    logic [$clog2(RST_CYC+1)-1:0] cnt_q;
    logic       plug_q;
    logic       plug_prev_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic       sw_reset_req;

    logic       aw_done_q, w_done_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_IRQ) || (a == OFF_MASK);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order.

    logic wr_go;
    assign wr_go = aw_done_q && w_done_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_done_q     <= 1'b0;
            w_done_q      <= 1'b0;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_done_q && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_done_q && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done_q <= 1'b1;
                wdata_q  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
                aw_done_q    <= 1'b0;
                w_done_q     <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_ctrl, wr_irq, wr_mask;
    assign wr_ctrl = wr_go && (awaddr_q == OFF_CTRL);
    assign wr_irq  = wr_go && (awaddr_q == OFF_IRQ);
    assign wr_mask = wr_go && (awaddr_q == OFF_MASK);
    assign sw_reset_req = wr_ctrl && wdata_q[BIT_RESET];

    ////////////////////////////////////////////////////////////////////////////
    // Control bits. Software reset does not clear them, but the CTRL write that
    // requests it loads them from its own data, regulator setting included.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            ctrl_q.regulator_on             <= wdata_q[BIT_REGULATOR_ON];
            ctrl_q.detector_off             <= wdata_q[BIT_DETOFF];
            ctrl_q.regulator_voltage_select <= wdata_q[BIT_VSEL +: 2];
            ctrl_q.plug_irq_enable          <= wdata_q[BIT_PLUG_IRQ_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Plug detection: set by upper threshold, cleared below lower threshold.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            plug_q      <= 1'b0;
            plug_prev_q <= 1'b0;
        end else begin
            plug_prev_q <= plug_q;
            if (ctrl_q.detector_off || upper_detect) begin
                plug_q <= 1'b1;
            end else if (!lower_detect) begin
                plug_q <= 1'b0;
            end
        end
    end

    logic plug_rise, plug_fall;
    assign plug_rise = plug_q && !plug_prev_q;
    assign plug_fall = !plug_q && plug_prev_q;

    // Bit 0 plug event, bit 1 unplug event; set wins over write-one clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 ? plug_rise : plug_fall) && ctrl_q.plug_irq_enable) begin
                    irq_stat_q[i] <= 1'b1;
                end else if (wr_irq && wdata_q[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
            if (wr_mask) begin
                irq_mask_q <= wdata_q[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer. The mode is latched as the reset phase starts.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_RESET;
            cnt_q   <= '0;
            mode_q  <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (sw_reset_req) begin
                        state_q            <= ST_RESET;
                        cnt_q              <= '0;
                        mode_q.usb_mode    <= plug_q;
                        mode_q.pll_enable  <= plug_q;
                        mode_q.clk_sel_pll <= plug_q;
                    end
                end
                ST_RESET: begin
                    if (cnt_q == 0) begin
                        mode_q.usb_mode    <= plug_q;
                        mode_q.pll_enable  <= plug_q;
                        mode_q.clk_sel_pll <= plug_q;
                    end
                    if (cnt_q == ($bits(cnt_q))'(RST_CYC - 1)) begin
                        state_q <= ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: state_q <= ST_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_switch_enable_n_o    <= 1'b0;
            usb_switch_enable_n_oe   <= 1'b0;
            io_hiz                   <= 1'b1;
            storage_io_ground        <= 1'b1;
            pll_enable               <= 1'b0;
            clk_sel_pll              <= 1'b0;
            regulator_on             <= 1'b0;
            regulator_voltage_select <= VSEL_3V5;
            detector_off             <= 1'b0;
            core_reset               <= 1'b1;
        end else begin
            usb_switch_enable_n_o    <= 1'b0;
            usb_switch_enable_n_oe   <= mode_q.usb_mode;
            io_hiz                   <= (state_q == ST_RESET);
            storage_io_ground        <= !storage_io_supply;
            pll_enable               <= mode_q.pll_enable;
            clk_sel_pll              <= mode_q.clk_sel_pll;
            regulator_on             <= ctrl_q.regulator_on;
            regulator_voltage_select <= ctrl_q.regulator_voltage_select;
            detector_off             <= ctrl_q.detector_off;
            core_reset               <= (state_q == ST_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel.

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        case (s_axi_araddr)
            OFF_CTRL: begin
                rd_val[BIT_REGULATOR_ON]      = ctrl_q.regulator_on;
                rd_val[BIT_DETOFF]     = ctrl_q.detector_off;
                rd_val[BIT_VSEL +: 2]  = ctrl_q.regulator_voltage_select;
                rd_val[BIT_PLUG_IRQ_ENABLE]      = ctrl_q.plug_irq_enable;
            end
            OFF_STATUS: begin
                rd_val[BIT_PLUG]  = plug_q;
                rd_val[BIT_UPPER] = upper_detect || ctrl_q.detector_off;
                rd_val[BIT_LOWER] = lower_detect || ctrl_q.detector_off;
                rd_val[BIT_USBM]  = mode_q.usb_mode;
                rd_val[BIT_INRST] = (state_q == ST_RESET);
            end
            OFF_IRQ:  rd_val[1:0] = irq_stat_q;
            OFF_MASK: rd_val[1:0] = irq_mask_q;
            default:  rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_plug_rise_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (plug_rise && ctrl_q.plug_irq_enable) |=> irq_stat_q[0])
        else $error("plug event not latched");
    a_unplug_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (plug_fall && ctrl_q.plug_irq_enable) |=> irq_stat_q[1])
        else $error("unplug event not latched");
    a_reset_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_reset_req && state_q == ST_RUN |=> ##1 io_hiz && core_reset)
        else $error("software reset did not tri-state I/O");
    a_usb_switch_on: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(mode_q.usb_mode) |=> usb_switch_enable_n_oe && !usb_switch_enable_n_o)
        else $error("switch not driven low in USB mode");
    a_standalone_float: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(mode_q.usb_mode) |=> !usb_switch_enable_n_oe)
        else $error("switch not floated in stand-alone mode");
    a_pll_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        !mode_q.usb_mode |=> !pll_enable && !clk_sel_pll)
        else $error("PLL running in stand-alone mode");
    a_storage_gnd: assert property (@(posedge aclk) disable iff (!aresetn)
        !storage_io_supply |=> storage_io_ground)
        else $error("storage I/Os not grounded");
    a_vsel_out: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl |=> ##1 regulator_voltage_select == $past(wdata_q[BIT_VSEL +: 2], 2))
        else $error("voltage select not applied");
    a_regulator_out: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl |=> ##1 regulator_on == $past(wdata_q[BIT_REGULATOR_ON], 2))
        else $error("regulator enable not applied");
    a_plug_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        upper_detect |=> plug_q)
        else $error("plug flag not set");
    a_mode_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_RUN && !sw_reset_req) |=> $stable(mode_q.usb_mode))
        else $error("mode changed outside reset");

endmodule : usb_power_mode_switch
`default_nettype wire

// ### sim/supply_partner.sv
// Model of the USB supply, the external supply switch and the storage rail switch.
`default_nettype none
module supply_partner #(
    parameter int UPPER_MV    = 3600, // Level at which the upper detector trips.
    parameter int LOWER_MV    = 3000, // Level below which the lower detector drops.
    parameter int RAMP_MV     = 250,  // Supply slew per cycle; small values model a slow cable.
    parameter int STORE_DELAY = 8     // Cycles held off before the storage rail is switched on.
) (
    input  wire logic aclk,              // System clock.
    input  wire logic plugged,           // Cable present.
    input  wire logic store_req,         // Software asks for the external storage switch.
    input  wire logic sw_en_n_o,         // Switch enable pin value from the device.
    input  wire logic sw_en_n_oe,        // Switch enable pin drive from the device.
    output logic      upper_detect,      // Supply above the upper threshold.
    output logic      lower_detect,      // Supply above the lower threshold.
    output logic      storage_io_supply, // Storage rail present.
    output logic      switch_on          // External supply switch conducting.
);
    int   level_mv = 0;
    int   wait_q   = 0;
    logic pin;

    // The gate pull-up keeps the switch off whenever the device floats the pin.
    assign pin       = sw_en_n_oe ? sw_en_n_o : 1'b1;
    assign switch_on = !pin;

    always @(posedge aclk) begin
        if (plugged) begin
            level_mv <= (level_mv + RAMP_MV > 5000) ? 5000 : level_mv + RAMP_MV;
        end else begin
            // The supply ramps down to 0 mV, below the lower threshold, so an unplug is seen.
            level_mv <= (level_mv < RAMP_MV) ? 0 : level_mv - RAMP_MV;
        end
        wait_q <= store_req ? ((wait_q < STORE_DELAY) ? wait_q + 1 : wait_q) : 0;
    end

    assign upper_detect      = level_mv >= UPPER_MV;
    assign lower_detect      = level_mv >= LOWER_MV;
    assign storage_io_supply = wait_q == STORE_DELAY;
endmodule : supply_partner
`default_nettype wire

// ### sim/usb_power_mode_switch_tb.sv
// Self-checking testbench for the USB power mode switch.
`default_nettype none
module usb_power_mode_switch_tb
    import pwr_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RC = 4;
    logic        aclk = 1'b0, aresetn = 1'b0, plugged = 1'b0, store_req = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, switch_on;
    logic [1:0]  bresp, rresp, vsel;
    logic        upper, lower, sup, en_o, en_oe, io_hiz, gnd, pll, clk_pll, reg_on, core_rst, irq, det_off;
    logic [31:0] rdq[$], rrq[$], brq[$];
    int          fails = 0, n_tests = 0, cycles = 0, seed = 99;

    usb_power_mode_switch #(.RST_CYC(RC)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .upper_detect(upper), .lower_detect(lower), .storage_io_supply(sup),
        .usb_switch_enable_n_o(en_o), .usb_switch_enable_n_oe(en_oe), .io_hiz(io_hiz),
        .storage_io_ground(gnd), .pll_enable(pll), .clk_sel_pll(clk_pll), .regulator_on(reg_on),
        .regulator_voltage_select(vsel), .detector_off(det_off), .core_reset(core_rst), .irq(irq));
    supply_partner #(.STORE_DELAY(8)) u_far (.aclk(aclk), .plugged(plugged), .store_req(store_req),
        .sw_en_n_o(en_o), .sw_en_n_oe(en_oe), .upper_detect(upper), .lower_detect(lower),
        .storage_io_supply(sup), .switch_on(switch_on));

    always #50 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, 32'(exp), 32'(got));
    endtask : chk_bit

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : settle

    // Address and data are offered together and released one by one as each is taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        brq.push_back(32'(RESP_OKAY));
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] r);
        rdq.push_back(exp);
        rrq.push_back(32'(r));
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    task automatic sw_reset(input logic [31:0] ctrl);
        wr(OFF_CTRL, ctrl | 32'h100);
        settle(3);
        chk_bit("io_hiz", 1'b1, io_hiz);
        chk_bit("core_reset", 1'b1, core_rst);
    endtask : sw_reset

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && rdq.size() > 0) begin
            chk_word("rdata", rdq.pop_front(), rdata);
            chk_word("rresp", rrq.pop_front(), 32'(rresp));
        end
        if (bvalid === 1'b1 && bready === 1'b1 && brq.size() > 0) begin
            chk_word("bresp", brq.pop_front(), 32'(bresp));
        end
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        settle(1);
        chk_bit("io_hiz", 1'b1, io_hiz);
        settle(RC + 3);
        chk_bit("io_hiz", 1'b0, io_hiz);
        chk_bit("switch_on", 1'b0, switch_on);
        chk_bit("storage_io_ground", 1'b1, gnd);
        rd(OFF_CTRL, 32'h0, RESP_OKAY);
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        rd(OFF_MASK, 32'h0, RESP_OKAY);
        rd(4'h2, 32'h0, RESP_SLVERR);
        // The loop index is the code itself: 0 is 3.5 V, 1 is 3.4 V, 2 is 3.3 V, 3 is 2.8 V.
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            d[8:0] = {5'h0, i[1:0], 1'b0, d[0]};
            wr(OFF_CTRL, d);
            settle(3);
            chk_word("regulator_voltage_select", 32'(i), 32'(vsel));
            chk_bit("regulator_on", d[0], reg_on);
            rd(OFF_CTRL, d & 32'h1d, RESP_OKAY);
        end
        wr(OFF_CTRL, 32'h10);
        wr(OFF_MASK, 32'h3);
        @(posedge aclk);
        plugged <= 1'b1;
        for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge aclk);
        settle(1);
        chk_bit("irq", 1'b1, irq);
        rd(OFF_STATUS, 32'h7, RESP_OKAY);
        rd(OFF_IRQ, 32'h1, RESP_OKAY);
        wr(OFF_IRQ, 32'h1);
        settle(3);
        chk_bit("irq", 1'b0, irq);
        sw_reset(32'h10);
        chk_bit("switch_on", 1'b1, switch_on);
        chk_bit("pll_enable", 1'b1, pll);
        settle(RC + 3);
        chk_bit("io_hiz", 1'b0, io_hiz);
        chk_bit("switch_on", 1'b1, switch_on);
        chk_bit("clk_sel_pll", 1'b1, clk_pll);
        rd(OFF_STATUS, 32'hf, RESP_OKAY);
        rd(OFF_CTRL, 32'h10, RESP_OKAY);
        wr(OFF_MASK, 32'h0);
        @(posedge aclk);
        plugged <= 1'b0;
        settle(40);
        chk_bit("irq", 1'b0, irq);
        rd(OFF_IRQ, 32'h2, RESP_OKAY);
        rd(OFF_STATUS, 32'h8, RESP_OKAY);
        wr(OFF_MASK, 32'h2);
        settle(3);
        chk_bit("irq", 1'b1, irq);
        wr(OFF_IRQ, 32'h2);
        sw_reset(32'h10);
        chk_bit("switch_on", 1'b0, switch_on);
        chk_bit("pll_enable", 1'b0, pll);
        chk_bit("clk_sel_pll", 1'b0, clk_pll);
        settle(RC + 3);
        chk_bit("switch_on", 1'b0, switch_on);
        rd(OFF_STATUS, 32'h0, RESP_OKAY);
        wr(OFF_CTRL, 32'h0);
        settle(3);
        chk_bit("regulator_on", 1'b0, reg_on);
        @(posedge aclk);
        store_req <= 1'b1;
        while (sup !== 1'b1) @(posedge aclk);
        settle(2);
        chk_bit("storage_io_ground", 1'b0, gnd);
        // Powering the detector down forces the plug flag and both thresholds high.
        wr(OFF_CTRL, 32'h2);
        settle(3);
        chk_bit("detector_off", 1'b1, det_off);
        rd(OFF_STATUS, 32'h7, RESP_OKAY);
        conclude();
    end
endmodule : usb_power_mode_switch_tb
`default_nettype wire
